// ==== hdl/fsw_pkg.sv ====
/*
  Constants for the flash self-write sequencer: register offsets, field
  positions, unlock keys and timing counts.
  Assumes a 100 MHz core clock and a 32-bit AHB-Lite register bus.
*/
package fsw_pkg;
  // Register byte offsets (one aligned word each)
  localparam logic [7:0] FSW_OFF_CTRL    = 8'h00;  // Control: enable, start, read
  localparam logic [7:0] FSW_OFF_UNLOCK  = 8'h04;  // Unlock key location, no storage
  localparam logic [7:0] FSW_OFF_ADDR_LO = 8'h08;  // Address low byte
  localparam logic [7:0] FSW_OFF_ADDR_HI = 8'h0c;  // Address high bits
  localparam logic [7:0] FSW_OFF_DATA_LO = 8'h10;  // Data low byte
  localparam logic [7:0] FSW_OFF_DATA_HI = 8'h14;  // Data high bits
  localparam logic [7:0] FSW_OFF_STATUS  = 8'h18;  // Block status

  // Control field positions
  localparam int FSW_CTRL_RD  = 0;  // Read request
  localparam int FSW_CTRL_WR  = 1;  // Write start
  localparam int FSW_CTRL_EN  = 2;  // Program allow

  // Status field positions
  localparam int FSW_ST_BUSY  = 0;  // Erase or program in progress
  localparam int FSW_ST_PWRT  = 1;  // Power-up timer still running
  localparam int FSW_ST_ARMED = 2;  // Unlock keys accepted

  // Unlock keys
  localparam logic [7:0] FSW_KEY1 = 8'h55;
  localparam logic [7:0] FSW_KEY2 = 8'haa;

  // Geometry
  localparam int         FSW_AW        = 10;     // Word address width
  localparam int         FSW_DW        = 14;     // Word data width
  localparam logic [1:0] FSW_LAST_SLOT = 2'b11;  // Slot that triggers erase+program
  localparam int         FSW_ROW_SH    = 4;      // Row of sixteen words

  // Timing
  localparam int FSW_CLK_HZ      = 100_000_000;
  localparam int FSW_PWRT_MS     = 64;  // Power-up timer
  localparam int FSW_ERASE_MS    = 4;   // Typical erase stall
  localparam int FSW_SETUP_CYC   = 2;   // Setup cycles after start
  localparam int FSW_PWRT_CYC    = FSW_PWRT_MS * (FSW_CLK_HZ / 1000);
  localparam int FSW_ERASE_CYC   = FSW_ERASE_MS * (FSW_CLK_HZ / 1000);

  // AHB-Lite codes
  localparam logic [1:0] FSW_HTRANS_NONSEQ = 2'b10;
  localparam logic [2:0] FSW_HSIZE_WORD    = 3'b010;
endpackage

// ==== hdl/fsw_sequencer.sv ====
/*
  Flash self-write sequencer: AHB-Lite register slave, four-word write
  buffer, unlock guard, power-up write inhibit, row erase and block program
  sequencing toward the flash array, and a CPU stall output.
  Assumes the flash array performs an erase or a program in one strobe
  cycle and times its own pulses; the stall timing is owned here.
*/
// The register offsets and the AHB-Lite slave port were left to the implementer.
// Operation
// - Buffer holds four words, base aligned 00
// - Block write erases row, programs four words
// - Block write aligned, never spans blocks
// - Slots 00 to 10 only latch, no stall
// - Slot 11 erases row then programs buffer
// - Two setup cycles after start
// - Stall execution during erase, 4 ms
// - Resume after write cycle completes
// - Program allow cleared at power-up
// - Power-up timer blocks all writes
// - Code lock leaves self access unscrambled
// - Guard refuses serial port, not CPU
// - Start bit set-only, hardware clears
// - Program allow low inhibits array changes
// - Unlock location reads zero
`timescale 1ns/10ps
module fsw_sequencer
  import fsw_pkg::*;
#(
  parameter int PWRT_CYC  = FSW_PWRT_CYC,   // Power-up write inhibit length
  parameter int ERASE_CYC = FSW_ERASE_CYC   // Erase stall length
) (
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                sys_rst,
  // AHB-Lite slave
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic      [31:0]         hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  // Protection straps
  input  wire logic                code_lock,
  input  wire logic [1:0]          self_write_guard,
  input  wire logic                serial_programming_port,
  output logic                     serial_write_refused,
  // CPU stall
  output logic                     cpu_stall,
  // Flash array
  output logic                     fl_erase,
  output logic                     fl_prog,
  output logic                     fl_read,
  output logic [FSW_AW-1:0]        fl_addr,
  output logic [FSW_DW-1:0]        fl_wdata,
  input  wire logic [FSW_DW-1:0]   fl_rdata
);
  // Elaboration checks
  if (PWRT_CYC < 1 || ERASE_CYC < 1) begin : g_chk
    $error("fsw_sequencer: counts must be at least one");
  end

  // Sequencer states, one-hot
  typedef enum logic [5:0] {
    FSW_IDLE  = 6'b000001,
    FSW_SETUP = 6'b000010,
    FSW_ERASE = 6'b000100,
    FSW_PROG  = 6'b001000,
    FSW_DONE  = 6'b010000,
    FSW_READ  = 6'b100000
  } fsw_state_t;

  // Unlock tracking states
  typedef enum logic [2:0] {
    FSW_K_NONE = 3'b001,
    FSW_K_ONE  = 3'b010,
    FSW_K_TWO  = 3'b100
  } fsw_key_t;

  fsw_state_t        state_r;        // Sequencer state
  fsw_key_t          key_r;          // Unlock progress
  logic [7:0]        addr_lo_r;      // Address low byte
  logic [1:0]        addr_hi_r;      // Address high bits
  logic [7:0]        data_lo_r;      // Data low byte
  logic [5:0]        data_hi_r;      // Data high bits
  logic              allow_r;        // Program allow bit
  logic              wr_r;           // Start bit
  logic              rd_r;           // Read bit
  logic [FSW_DW-1:0] buf_r [4];      // Write buffer
  logic [FSW_AW-1:0] base_r;         // Block base held for programming
  logic [1:0]        slot_r;         // Slot being latched or programmed
  logic [31:0]       cnt_r;          // Setup and erase counter
  logic [31:0]       pwrt_r;         // Power-up timer
  logic              pwrt_run;       // Power-up timer still running

  // Bus address phase capture
  logic              dp_act_r;       // Data phase pending
  logic              dp_wr_r;        // Pending is a write
  logic [7:0]        dp_off_r;       // Pending offset

  logic              wr_hit;         // Register write strobe this cycle
  logic [31:0]       wval;           // Write value
  logic              start_ok;       // Start accepted

  // Decode of a register offset, used by write and read paths
  function automatic logic is_off(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction

  assign hreadyout = 1'b1;  // Zero wait states
  assign hresp     = 1'b0;  // Always OKAY
  assign wr_hit    = dp_act_r & dp_wr_r;
  assign wval      = hwdata;
  assign pwrt_run  = pwrt_r != 32'h0000_0000;

  // Address phase capture
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      dp_act_r <= 1'b0;
      dp_wr_r  <= 1'b0;
      dp_off_r <= 8'h00;
    end else if (hready) begin
      dp_act_r <= hsel & (htrans == FSW_HTRANS_NONSEQ) & (hsize == FSW_HSIZE_WORD);
      dp_wr_r  <= hwrite;
      dp_off_r <= haddr[7:0];
    end
  end

  // Power-up timer: counts down from reset, inhibits writes meanwhile
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pwrt_r <= 32'(PWRT_CYC);
    end else if (pwrt_run) begin
      pwrt_r <= pwrt_r - 32'd1;
    end
  end

  // Start accepted only straight after both keys, with allow set
  assign start_ok = wr_hit & is_off(dp_off_r, FSW_OFF_CTRL) & wval[FSW_CTRL_WR]
                  & (key_r == FSW_K_TWO) & allow_r & ~pwrt_run
                  & (state_r == FSW_IDLE);

  // Unlock tracking: any other register write breaks the sequence
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      key_r <= FSW_K_NONE;
    end else if (wr_hit) begin
      if (is_off(dp_off_r, FSW_OFF_UNLOCK) && wval[7:0] == FSW_KEY1) begin
        key_r <= FSW_K_ONE;
      end else if (is_off(dp_off_r, FSW_OFF_UNLOCK) && wval[7:0] == FSW_KEY2
                   && key_r == FSW_K_ONE) begin
        key_r <= FSW_K_TWO;
      end else begin
        key_r <= FSW_K_NONE;  // keys must immediately precede start
      end
    end
  end

  // Address and data registers; a read fills data from the array
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      addr_lo_r <= 8'h00;
      addr_hi_r <= 2'b00;
      data_lo_r <= 8'h00;
      data_hi_r <= 6'h00;
    end else if (state_r == FSW_READ) begin
      data_lo_r <= fl_rdata[7:0];  // plain data, no scrambling
      data_hi_r <= fl_rdata[FSW_DW-1:8];
    end else if (wr_hit) begin
      if (is_off(dp_off_r, FSW_OFF_ADDR_LO)) begin
        addr_lo_r <= wval[7:0];
      end else if (is_off(dp_off_r, FSW_OFF_ADDR_HI)) begin
        addr_hi_r <= wval[1:0];
      end else if (is_off(dp_off_r, FSW_OFF_DATA_LO)) begin
        data_lo_r <= wval[7:0];
      end else if (is_off(dp_off_r, FSW_OFF_DATA_HI)) begin
        data_hi_r <= wval[5:0];
      end
    end
  end

  // Program allow: plain read/write, cleared at reset
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      allow_r <= 1'b0;
    end else if (wr_hit && is_off(dp_off_r, FSW_OFF_CTRL)) begin
      allow_r <= wval[FSW_CTRL_EN];
    end
  end

  // Start and read bits: software sets, hardware clears at completion
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wr_r <= 1'b0;
      rd_r <= 1'b0;
    end else begin
      if (start_ok) begin
        wr_r <= 1'b1;  // a written zero has no effect
      end else if (state_r == FSW_DONE) begin
        wr_r <= 1'b0;
      end
      if (wr_hit && is_off(dp_off_r, FSW_OFF_CTRL) && wval[FSW_CTRL_RD]
          && state_r == FSW_IDLE) begin
        rd_r <= 1'b1;
      end else if (state_r == FSW_READ) begin
        rd_r <= 1'b0;
      end
    end
  end

  // Sequencer: setup, erase (stalled), program four slots, done
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_r <= FSW_IDLE;
      cnt_r   <= 32'h0000_0000;
      slot_r  <= 2'b00;
      base_r  <= '0;
    end else begin
      case (state_r)
        FSW_IDLE: begin
          if (start_ok) begin
            state_r <= FSW_SETUP;
            cnt_r   <= 32'(FSW_SETUP_CYC - 1);
            slot_r  <= addr_lo_r[1:0];
            base_r  <= {addr_hi_r, addr_lo_r[7:2], 2'b00};
          end else if (rd_r) begin
            state_r <= FSW_READ;
          end
        end
        FSW_SETUP: begin
          if (cnt_r != 32'h0000_0000) begin
            cnt_r <= cnt_r - 32'd1;
          end else if (slot_r == FSW_LAST_SLOT) begin
            state_r <= FSW_ERASE;
            cnt_r   <= 32'(ERASE_CYC - 1);
            slot_r  <= 2'b00;
          end else begin
            state_r <= FSW_DONE;  // buffer latch only
          end
        end
        FSW_ERASE: begin
          if (cnt_r != 32'h0000_0000) begin
            cnt_r <= cnt_r - 32'd1;
          end else begin
            state_r <= FSW_PROG;
          end
        end
        FSW_PROG: begin
          slot_r <= slot_r + 2'd1;  // four words, ascending
          if (slot_r == FSW_LAST_SLOT) begin
            state_r <= FSW_DONE;
          end
        end
        FSW_DONE: state_r <= FSW_IDLE;
        FSW_READ: state_r <= FSW_IDLE;
        default:  state_r <= FSW_IDLE;
      endcase
    end
  end

  // Buffer latch at the end of setup for the addressed slot
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      buf_r <= '{default: '0};
    end else if (state_r == FSW_SETUP && cnt_r == 32'h0000_0000) begin
      buf_r[slot_r] <= {data_hi_r, data_lo_r};
    end
  end

  // Array strobes; allow is rechecked so clearing it aborts array changes
  assign fl_erase = (state_r == FSW_ERASE) & (cnt_r == 32'h0000_0000)
                    & allow_r;
  assign fl_prog  = (state_r == FSW_PROG) & allow_r;
  assign fl_read  = (state_r == FSW_READ);
  // Erase targets the row base, program walks the block slots
  assign fl_addr  = (state_r == FSW_ERASE)
                    ? {base_r[FSW_AW-1:FSW_ROW_SH], 4'h0}
                    : (state_r == FSW_PROG) ? {base_r[FSW_AW-1:2], slot_r}
                    : {addr_hi_r, addr_lo_r};
  assign fl_wdata = buf_r[slot_r];

  // CPU held only during erase and program; latch-only starts never stall
  assign cpu_stall = (state_r == FSW_ERASE) | (state_r == FSW_PROG);

  // Guarded regions refuse the serial port; CPU path ignores the guard
  assign serial_write_refused = serial_programming_port
                                & (self_write_guard != 2'b11);

  // Read data: registered, unlock location reads zero
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans == FSW_HTRANS_NONSEQ && !hwrite) begin
      if (is_off(haddr[7:0], FSW_OFF_CTRL)) begin
        hrdata <= {29'h0, allow_r, wr_r, rd_r};
      end else if (is_off(haddr[7:0], FSW_OFF_ADDR_LO)) begin
        hrdata <= {24'h0, addr_lo_r};
      end else if (is_off(haddr[7:0], FSW_OFF_ADDR_HI)) begin
        hrdata <= {30'h0, addr_hi_r};
      end else if (is_off(haddr[7:0], FSW_OFF_DATA_LO)) begin
        hrdata <= {24'h0, data_lo_r};
      end else if (is_off(haddr[7:0], FSW_OFF_DATA_HI)) begin
        hrdata <= {26'h0, data_hi_r};
      end else if (is_off(haddr[7:0], FSW_OFF_STATUS)) begin
        hrdata <= {29'h0, key_r == FSW_K_TWO, pwrt_run, cpu_stall};
      end else begin
        hrdata <= 32'h0000_0000;  // unlock and unmapped read zero
      end
    end
  end

  // code_lock has no effect on the self path, by design
  logic unused_lock;
  assign unused_lock = code_lock;
endmodule

// ==== test/fsw_flash_model.sv ====
/*
  Behavioural flash array facing the sequencer: row erase, word program,
  same-cycle read. Assumes strobes are sampled on the core clock edge.
*/
`timescale 1ns/10ps
module fsw_flash_model (
  // Clock
  input  wire logic                      core_clk,
  // Strobes and address from the sequencer
  input  wire logic                      fl_erase,
  input  wire logic                      fl_prog,
  input  wire logic                      fl_read,
  input  wire logic [fsw_pkg::FSW_AW-1:0] fl_addr,
  input  wire logic [fsw_pkg::FSW_DW-1:0] fl_wdata,
  // Read data
  output logic      [fsw_pkg::FSW_DW-1:0] fl_rdata
);
  import fsw_pkg::*;
  logic [FSW_DW-1:0] mem [1024];  // Cells, blank as zero so an erase shows
  initial foreach (mem[i]) mem[i] = '0;
  // Erase sets a whole sixteen-word row, program writes one word
  always @(posedge core_clk) begin
    if (fl_erase === 1'b1) begin
      for (int i = 0; i < 16; i++) mem[{fl_addr[9:4], 4'(i)}] = '1;
    end
    if (fl_prog === 1'b1) mem[fl_addr] = fl_wdata;
  end
  // Outside a read the lines carry the inverse, so a stale value never matches
  assign fl_rdata = fl_read ? mem[fl_addr] : ~mem[fl_addr];
endmodule

// ==== test/fsw_sequencer_checker.sv ====
/*
  Concurrent checks on the sequencer ports.
  Assumes it is bound into fsw_sequencer with the same count parameters.
*/
`timescale 1ns/10ps
module fsw_sequencer_checker #(
  parameter int PWRT_CYC  = 20,  // Power-up inhibit length
  parameter int ERASE_CYC = 10   // Erase stall length
) (
  // Clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      sys_rst,
  // Bus
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic                      hready,
  input  wire logic [31:0]               hrdata,
  // Protection
  input  wire logic [1:0]                self_write_guard,
  input  wire logic                      serial_programming_port,
  input  wire logic                      serial_write_refused,
  // Stall and array
  input  wire logic                      cpu_stall,
  input  wire logic                      fl_erase,
  input  wire logic                      fl_prog,
  input  wire logic [fsw_pkg::FSW_AW-1:0] fl_addr
);
  import fsw_pkg::*;
  int stall_cnt_r;  // Length of the current stall
  int pwrt_cnt_r;   // Cycles since reset, saturating
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Count stall cycles so the whole stall length can be judged at its end
  always_ff @(posedge core_clk) begin
    if (sys_rst || !cpu_stall) stall_cnt_r <= 0;
    else stall_cnt_r <= stall_cnt_r + 1;
  end
  // Power-up window seen from outside
  always_ff @(posedge core_clk) begin
    if (sys_rst) pwrt_cnt_r <= 0;
    else if (pwrt_cnt_r < PWRT_CYC) pwrt_cnt_r <= pwrt_cnt_r + 1;
  end
  a_unlock_reads_zero: assert property (
    hsel && hready && htrans == FSW_HTRANS_NONSEQ && !hwrite && haddr[7:0] == FSW_OFF_UNLOCK
    |=> hrdata == 32'h0) else $error("unlock read not zero");
  a_guard_refuse: assert property (serial_write_refused ==
    (serial_programming_port && self_write_guard != 2'b11)) else $error("refusal wrong");
  a_erase_stalls: assert property (fl_erase |-> cpu_stall) else $error("erase without stall");
  a_prog_follows: assert property (fl_erase |=> fl_prog) else $error("no program after erase");
  a_prog_four: assert property ($rose(fl_prog) |-> fl_prog[*4] ##1 !fl_prog)
    else $error("program burst not four words");
  a_block_aligned: assert property ($rose(fl_prog) |-> fl_addr[1:0] == 2'b00)
    else $error("block not aligned");
  a_block_ascends: assert property (fl_prog && $past(fl_prog) |->
    fl_addr == $past(fl_addr) + 10'd1) else $error("block address not sequential");
  a_stall_length: assert property ($fell(cpu_stall) && !$past(sys_rst) |->
    stall_cnt_r == ERASE_CYC + 4) else $error("stall length wrong");
  a_pwrt_quiet: assert property (pwrt_cnt_r < PWRT_CYC |-> !fl_erase && !fl_prog)
    else $error("array strobe during power-up");
endmodule
bind fsw_sequencer fsw_sequencer_checker #(.PWRT_CYC(PWRT_CYC), .ERASE_CYC(ERASE_CYC))
  fsw_sequencer_checker_inst (.core_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hready,
  .hrdata, .self_write_guard, .serial_programming_port, .serial_write_refused, .cpu_stall,
  .fl_erase, .fl_prog, .fl_addr);

// ==== test/testbench.sv ====
/*
  Self-checking bench for the sequencer: AHB-Lite master tasks, flash model.
  Assumes the shortened power-up and erase counts set below.
*/
`timescale 1ns/10ps
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin fails++; \
  $display("mismatch %s expected %h seen %h", n, e, a); end end
module testbench;
  import fsw_pkg::*;
  localparam int PW = 200;  // Short power-up inhibit keeps the run brief
  localparam int ER = 10;   // Short erase stall
  typedef struct packed {logic [7:0] a, w, e; logic [3:0] s;} fsw_row_t;
  logic core_clk, sys_rst, hsel, hwrite, hreadyout, hresp, code_lock;
  logic serial_programming_port, serial_write_refused, cpu_stall, fl_erase, fl_prog, fl_read;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans, self_write_guard;
  logic [2:0] hsize;
  logic [9:0] fl_addr;
  logic [13:0] fl_wdata, fl_rdata;
  logic [13:0] keep_w, exp_w;  // Word carried over in a partial block, and its expectation
  int fails, samples_checked, stall_n;
  fsw_row_t rows [5] = '{{FSW_OFF_ADDR_LO, 8'hff, 8'hff, 4'b0011},
    {FSW_OFF_ADDR_HI, 8'hff, 8'h03, 4'b1011}, {FSW_OFF_DATA_LO, 8'ha5, 8'ha5, 4'b1110},
    {FSW_OFF_DATA_HI, 8'hff, 8'h3f, 4'b0100}, {FSW_OFF_UNLOCK, 8'h55, 8'h00, 4'b1100}};
  fsw_sequencer #(.PWRT_CYC(PW), .ERASE_CYC(ER)) fsw_sequencer_inst (.core_clk, .sys_rst,
    .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
    .hresp, .code_lock, .self_write_guard, .serial_programming_port, .serial_write_refused,
    .cpu_stall, .fl_erase, .fl_prog, .fl_read, .fl_addr, .fl_wdata, .fl_rdata);
  fsw_flash_model fsw_flash_model_inst (.core_clk, .fl_erase, .fl_prog, .fl_read, .fl_addr,
    .fl_wdata, .fl_rdata);
  task summarize;
    if (fails == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Wait for hready at an edge, bounded
  task rdy;
    int n;
    n = 0;
    do begin @(posedge core_clk); n++; end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin fails++; summarize; end
  endtask
  // One single word transfer; read data lands in q
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1; htrans <= FSW_HTRANS_NONSEQ; hwrite <= w; haddr <= {24'h0, a};
    rdy;
    htrans <= 2'b00; hwdata <= d;
    rdy;
    q = hrdata;
  endtask
  // Load address and data, optionally the keys, then write control
  task start(input logic k, input logic [9:0] ad, input logic [13:0] dt, input logic [7:0] c);
    bus(1'b1, FSW_OFF_ADDR_LO, {24'h0, ad[7:0]});
    bus(1'b1, FSW_OFF_ADDR_HI, {30'h0, ad[9:8]});
    bus(1'b1, FSW_OFF_DATA_LO, {24'h0, dt[7:0]});
    bus(1'b1, FSW_OFF_DATA_HI, {26'h0, dt[13:8]});
    if (k) begin
      bus(1'b1, FSW_OFF_UNLOCK, 32'h55);
      bus(1'b1, FSW_OFF_UNLOCK, 32'haa);
    end
    bus(1'b1, FSW_OFF_CTRL, {24'h0, c});
  endtask
  // Poll until the self-clearing write bit drops
  task wait_done;
    int n;
    n = 0;
    do begin bus(1'b0, FSW_OFF_CTRL, 32'h0); n++; end while (q[FSW_CTRL_WR] !== 1'b0 && n < 200);
    if (q[FSW_CTRL_WR] !== 1'b0) begin fails++; summarize; end
  endtask
  initial begin core_clk = 1'b0; forever #5 core_clk = ~core_clk; end
  initial begin repeat (100000) @(posedge core_clk); fails++; summarize; end
  always @(posedge core_clk) if (cpu_stall === 1'b1) stall_n++;
  initial begin
    {hsel, hwrite, serial_programming_port, haddr, hwdata, htrans} = '0;
    hsize = FSW_HSIZE_WORD; code_lock = 1'b1; self_write_guard = 2'b11; sys_rst = 1'b1;
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    for (int a = 0; a < 24; a += 4) begin
      bus(1'b0, 8'(a), 32'h0);
      `CHK("reset value", 32'h0, q)
    end
    // A complete start inside the power-up window must be refused
    bus(1'b1, FSW_OFF_CTRL, 32'h4);
    start(1'b1, 10'h000, 14'h0, 8'h06);
    bus(1'b0, FSW_OFF_CTRL, 32'h0);
    `CHK("ctrl in power-up", 32'h4, q)
    for (int n = 0; n < 300; n++) begin
      bus(1'b0, FSW_OFF_STATUS, 32'h0);
      if (q[FSW_ST_PWRT] === 1'b0) break;
    end
    `CHK("power-up timer ends", 1'b0, q[FSW_ST_PWRT])
    foreach (rows[i]) begin
      self_write_guard <= rows[i].s[3:2];
      serial_programming_port <= rows[i].s[1];
      bus(1'b1, rows[i].a, {24'h0, rows[i].w});
      bus(1'b0, rows[i].a, 32'h0);
      `CHK("readback", rows[i].e, q[7:0])
      `CHK("serial refused", rows[i].s[0], serial_write_refused)
    end
    bus(1'b1, 8'h1c, 32'h12);
    bus(1'b0, FSW_OFF_ADDR_LO, 32'h0);
    `CHK("unmapped alias", 32'hff, q)
    start(1'b0, 10'h000, 14'h0, 8'h06);
    bus(1'b0, FSW_OFF_CTRL, 32'h0);
    `CHK("start without keys", 32'h4, q)
    bus(1'b1, FSW_OFF_CTRL, 32'h0);
    start(1'b1, 10'h000, 14'h0, 8'h02);
    bus(1'b0, FSW_OFF_CTRL, 32'h0);
    `CHK("start without allow", 32'h0, q)
    bus(1'b1, FSW_OFF_CTRL, 32'h4);
    self_write_guard <= 2'b00;  // CPU path must ignore the guard
    for (int i = 0; i < 4; i++) begin
      stall_n = 0;
      start(1'b1, 10'h15c + 10'(i), 14'h2a50 + 14'(i), 8'h06);
      if (i == 3) begin
        bus(1'b1, FSW_OFF_CTRL, 32'h4);
        bus(1'b0, FSW_OFF_CTRL, 32'h0);
        `CHK("write bit held", 32'h6, q)
      end
      wait_done;
      `CHK("stall cycles", (i == 3) ? ER + 4 : 0, stall_n)
    end
    for (int i = 0; i < 4; i++) begin
      `CHK("programmed", 14'h2a50 + 14'(i), fsw_flash_model_inst.mem[10'h15c + i])
    end
    `CHK("row erased", 14'h3fff, fsw_flash_model_inst.mem[10'h150])
    `CHK("next row kept", 14'h0, fsw_flash_model_inst.mem[10'h160])
    bus(1'b1, FSW_OFF_ADDR_LO, 32'h5d);
    bus(1'b1, FSW_OFF_CTRL, 32'h5);
    bus(1'b0, FSW_OFF_DATA_LO, 32'h0);
    bus(1'b0, FSW_OFF_DATA_LO, 32'h0);
    `CHK("locked read", 32'h51, q)
    // Rewrite word 2 only; the kept slots are read back and reloaded unchanged
    for (int i = 0; i < 4; i++) begin  // same procedure, next pass
      bus(1'b1, FSW_OFF_ADDR_LO, 32'h5c + 32'(i));
      bus(1'b1, FSW_OFF_CTRL, 32'h5);
      bus(1'b0, FSW_OFF_DATA_HI, 32'h0);  // Read lands a cycle late, skip this one
      bus(1'b0, FSW_OFF_DATA_LO, 32'h0);
      keep_w[7:0] = q[7:0];
      bus(1'b0, FSW_OFF_DATA_HI, 32'h0);
      keep_w[13:8] = q[5:0];
      start(1'b1, 10'h15c + 10'(i), (i == 2) ? 14'h0123 : keep_w, 8'h06);
      wait_done;
    end
    for (int i = 0; i < 4; i++) begin
      exp_w = (i == 2) ? 14'h0123 : 14'h2a50 + 14'(i);
      `CHK("partial block", exp_w, fsw_flash_model_inst.mem[10'h15c + i])
    end
    summarize;
  end
endmodule
